// *** hw/pwmdt_channel.sv ***
/*
  One PWM timer channel: saw or triangle counting, event counting,
  input capture, complementary outputs with automatic dead time and a
  level interrupt.
  Assumes one clock, asynchronous active-low reset, and a register
  master that never issues read and write strobes together.
*/
`timescale 1ns/1ps
`include "pwmdt_params.svh"

module pwmdt_channel
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        up_event_pin,
  input  wire logic        down_event_pin,
  input  wire logic        capture_pin,
  output logic             pos_out,
  output logic             neg_out,
  output logic             irq
);

  logic [6:0]                ctrl_r;
  pwmdt_pkg::pwmdt_cnt_t     period_r;
  pwmdt_pkg::pwmdt_cnt_t     cca_r;
  pwmdt_pkg::pwmdt_cnt_t     ccb_r;
  pwmdt_pkg::pwmdt_cnt_t     ndt_r;
  logic [1:0]                upsr_r;
  logic [1:0]                dnsr_r;
  pwmdt_pkg::pwmdt_cnt_t     cnt_r;
  pwmdt_pkg::pwmdt_cnt_t     cnt_nxt;
  pwmdt_pkg::pwmdt_state_t   state_r;
  pwmdt_pkg::pwmdt_state_t   state_nxt;
  logic [2:0]                stat_r;
  logic [2:0]                mask_r;
  logic                      pend_r;
  logic                      crest_r;
  logic [2:0]                up_sync_r;
  logic [2:0]                dn_sync_r;
  logic [2:0]                cap_sync_r;
  logic                      up_lvl_r;
  logic                      dn_lvl_r;
  logic                      cap_lvl_r;
  logic                      up_rise;
  logic                      dn_rise;
  logic                      cap_rise;
  logic                      run;
  logic                      auto_dt;
  logic                      capt_mode;
  logic                      tri_mode;
  logic                      one_shot;
  logic                      evt_mode;
  logic                      up_tick;
  logic                      dn_tick;
  logic                      crest;
  logic                      dterr_evt;
  logic                      wr_src;
  pwmdt_pkg::pwmdt_cnt_t     pos_pt;
  pwmdt_pkg::pwmdt_cnt_t     neg_pt;

  pwmdt_dt_if dt_bus ();

  // Register write decode
  function automatic logic wr_hit(input logic [3:0] off);
    wr_hit = reg_wr && (reg_addr == off);
  endfunction

  // Three-stage filter: a change counts once stages two and three agree
  function automatic logic settle(input logic [2:0] s, input logic lvl);
    settle = (s[1] == s[2]) ? s[2] : lvl;
  endfunction

  assign run       = ctrl_r[`PWMDT_CTRL_RUN];
  assign auto_dt   = ctrl_r[`PWMDT_CTRL_AUTODT];
  assign capt_mode = ctrl_r[`PWMDT_CTRL_CAPT];
  assign tri_mode  = ctrl_r[`PWMDT_CTRL_MD_LO + `PWMDT_MD_TRI_BIT];
  // Capture ignores the lower mode bits
  assign one_shot  = !capt_mode && !tri_mode &&
    (ctrl_r[`PWMDT_CTRL_MD_LO +: 2] == `PWMDT_MD_ONESHOT);
  // Event sources override the waveform walk in the up state; the down state keeps walking
  assign evt_mode  = (upsr_r != 2'h0) || (dnsr_r != 2'h0);

  // Sources of the dead-time calculation
  assign wr_src = wr_hit(`PWMDT_OFF_CCA) || wr_hit(`PWMDT_OFF_NDT) ||
                  wr_hit(`PWMDT_OFF_PERIOD) || wr_hit(`PWMDT_OFF_CTRL);

  // Calculator fed from compare A and negative dead time
  assign dt_bus.cca      = cca_r;
  assign dt_bus.ndt      = ndt_r;
  assign dt_bus.period   = period_r;
  assign dt_bus.tri_mode = tri_mode;

  pwmdt_dt_calc u_calc
  (
    .dt (dt_bus)
  );

  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_sync_r  <= 3'h0;
      dn_sync_r  <= 3'h0;
      cap_sync_r <= 3'h0;
    end
    else
    begin
      up_sync_r  <= {up_sync_r[1:0], up_event_pin};
      dn_sync_r  <= {dn_sync_r[1:0], down_event_pin};
      cap_sync_r <= {cap_sync_r[1:0], capture_pin};
    end
  end

  // Settled pin levels
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_lvl_r  <= 1'b0;
      dn_lvl_r  <= 1'b0;
      cap_lvl_r <= 1'b0;
    end
    else
    begin
      up_lvl_r  <= settle(up_sync_r, up_lvl_r);
      dn_lvl_r  <= settle(dn_sync_r, dn_lvl_r);
      cap_lvl_r <= settle(cap_sync_r, cap_lvl_r);
    end
  end

  assign up_rise  = settle(up_sync_r, up_lvl_r) && !up_lvl_r;
  assign dn_rise  = settle(dn_sync_r, dn_lvl_r) && !dn_lvl_r;
  assign cap_rise = settle(cap_sync_r, cap_lvl_r) && !cap_lvl_r;

  assign up_tick = (upsr_r[0] && up_rise) || (upsr_r[1] && dn_rise);
  assign dn_tick = (dnsr_r[0] && up_rise) || (dnsr_r[1] && dn_rise);

  // Counter walk
  always_comb
  begin
    cnt_nxt   = cnt_r;
    state_nxt = state_r;
    case (state_r)
      pwmdt_pkg::PWMDT_IDLE:
      begin
        if (run)
          state_nxt = pwmdt_pkg::PWMDT_UP;
      end
      pwmdt_pkg::PWMDT_UP:
      begin
        if (!run)
          state_nxt = pwmdt_pkg::PWMDT_IDLE;
        else if (evt_mode)
        begin
          if (up_tick && !dn_tick)
            cnt_nxt = cnt_r + 16'h0001;
          else if (dn_tick && !up_tick)
            cnt_nxt = cnt_r - 16'h0001;
        end
        else if (cnt_r < period_r)
          cnt_nxt = cnt_r + 16'h0001;
        else if (tri_mode)
        begin
          cnt_nxt   = cnt_r - 16'h0001;
          state_nxt = pwmdt_pkg::PWMDT_DOWN;
        end
        else if (one_shot)
          state_nxt = pwmdt_pkg::PWMDT_IDLE;
        else
          cnt_nxt = 16'h0000;
      end
      pwmdt_pkg::PWMDT_DOWN:
      begin
        if (!run)
          state_nxt = pwmdt_pkg::PWMDT_IDLE;
        else if (cnt_r != 16'h0000)
          cnt_nxt = cnt_r - 16'h0001;
        else
        begin
          cnt_nxt   = 16'h0001;
          state_nxt = pwmdt_pkg::PWMDT_UP;
        end
      end
      default:
        state_nxt = pwmdt_pkg::PWMDT_IDLE;
    endcase
  end

  assign crest = (state_r == pwmdt_pkg::PWMDT_UP) && run && !evt_mode &&
                 (cnt_r >= period_r);

  // Counter and state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r   <= 16'h0000;
      state_r <= pwmdt_pkg::PWMDT_IDLE;
    end
    else if (wr_hit(`PWMDT_OFF_CNT) && !run)
    begin
      cnt_r   <= reg_wdata[15:0];
      state_r <= state_nxt;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      state_r <= state_nxt;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r   <= `PWMDT_RST_CTRL;
      period_r <= `PWMDT_RST_PERIOD;
      ndt_r    <= `PWMDT_RST_NDT;
      upsr_r   <= 2'h0;
      dnsr_r   <= 2'h0;
      mask_r   <= 3'h0;
    end
    else
    begin
      // Mode field taken as written; stopping first is up to software
      if (wr_hit(`PWMDT_OFF_CTRL))
        ctrl_r <= reg_wdata[6:0] & `PWMDT_CTRL_USED;
      if (wr_hit(`PWMDT_OFF_PERIOD))
        period_r <= reg_wdata[15:0];
      if (wr_hit(`PWMDT_OFF_NDT))
        ndt_r <= reg_wdata[15:0];
      if (wr_hit(`PWMDT_OFF_UPSR))
        upsr_r <= reg_wdata[1:0];
      if (wr_hit(`PWMDT_OFF_DNSR))
        dnsr_r <= reg_wdata[1:0];
      if (wr_hit(`PWMDT_OFF_MASK))
        mask_r <= reg_wdata[2:0];
    end
  end

  // Compare A: software write or input capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cca_r <= `PWMDT_RST_CC;
    else if (capt_mode && cap_rise)
      cca_r <= cnt_r;
    else if (wr_hit(`PWMDT_OFF_CCA))
      cca_r <= reg_wdata[15:0];
  end

  // Update pending and crest markers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_r  <= 1'b0;
      crest_r <= 1'b0;
    end
    else
    begin
      pend_r  <= wr_src;
      crest_r <= crest && tri_mode;
    end
  end

  // Compare B: software value, or computed value in auto dead time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ccb_r <= `PWMDT_RST_CC;
    else if (auto_dt)
    begin
      // Reload after update; and after triangle crest; adjusted
      if (pend_r || crest_r)
        ccb_r <= dt_bus.neg_cmp;
    end
    // Direct writes only count outside auto dead time
    else if (wr_hit(`PWMDT_OFF_CCB))
      ccb_r <= reg_wdata[15:0];
  end

  assign pos_pt = auto_dt ? dt_bus.pos_cmp : cca_r;
  assign neg_pt = ccb_r;

  // Complementary outputs; one-shot overlap not corrected
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_out <= 1'b0;
      neg_out <= 1'b0;
    end
    else if (state_r == pwmdt_pkg::PWMDT_IDLE || capt_mode)
    begin
      pos_out <= 1'b0;
      neg_out <= 1'b0;
    end
    else
    begin
      pos_out <= (cnt_r < pos_pt);
      neg_out <= (cnt_r >= neg_pt);
    end
  end

  // Error event raised when an adjusted value is loaded
  assign dterr_evt = auto_dt && (pend_r || crest_r) && dt_bus.dt_err;

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stat_r <= 3'h0;
    else
    begin
      stat_r <= (stat_r & ~((wr_hit(`PWMDT_OFF_STAT)) ? reg_wdata[2:0]
                                                       : 3'h0))
                | {capt_mode && cap_rise, crest, dterr_evt};
    end
  end

  // Interrupt level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(stat_r & mask_r);
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `PWMDT_OFF_CTRL:   reg_rdata <= {25'h0, ctrl_r};
        `PWMDT_OFF_PERIOD: reg_rdata <= {16'h0, period_r};
        `PWMDT_OFF_CCA:    reg_rdata <= {16'h0, cca_r};
        `PWMDT_OFF_CCB:    reg_rdata <= {16'h0, ccb_r};
        `PWMDT_OFF_NDT:    reg_rdata <= {16'h0, ndt_r};
        `PWMDT_OFF_UPSR:   reg_rdata <= {30'h0, upsr_r};
        `PWMDT_OFF_DNSR:   reg_rdata <= {30'h0, dnsr_r};
        `PWMDT_OFF_CNT:    reg_rdata <= {16'h0, cnt_r};
        `PWMDT_OFF_STAT:   reg_rdata <= {29'h0, stat_r};
        `PWMDT_OFF_MASK:   reg_rdata <= {29'h0, mask_r};
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule

// *** hw/pwmdt_dt_calc.sv ***
/*
  Dead-time calculator: derives the negative-phase compare point from
  compare A and the negative dead time, and adjusts both on error.
  Assumes inputs are stable registers of the same clock domain.
*/
`timescale 1ns/1ps

module pwmdt_dt_calc
(
  pwmdt_dt_if.calc dt
);

  logic [16:0] raw_sum;

  // Negative point lies dead time after the positive point (up count)
  assign raw_sum = {1'b0, dt.cca} + {1'b0, dt.ndt};

  // Past the period: pin negative point to period, pull positive back
  always_comb
  begin
    dt.dt_err  = (raw_sum > {1'b0, dt.period});
    dt.neg_cmp = raw_sum[15:0];
    dt.pos_cmp = dt.cca;
    if (dt.dt_err)
    begin
      dt.neg_cmp = dt.period;
      if (dt.ndt > dt.period)
        dt.pos_cmp = 16'h0000;
      else
        dt.pos_cmp = dt.period - dt.ndt;
    end
  end

endmodule

// *** hw/pwmdt_dt_if.sv ***
/*
  Interface carrying compare inputs and dead-time results between the
  channel and its calculator.
  Assumes both ends run combinationally within one clock domain.
*/
`timescale 1ns/1ps

interface pwmdt_dt_if;
  pwmdt_pkg::pwmdt_cnt_t cca;
  pwmdt_pkg::pwmdt_cnt_t ndt;
  pwmdt_pkg::pwmdt_cnt_t period;
  logic                  tri_mode;
  pwmdt_pkg::pwmdt_cnt_t neg_cmp;
  pwmdt_pkg::pwmdt_cnt_t pos_cmp;
  logic                  dt_err;

  modport calc (input  cca, ndt, period, tri_mode,
                output neg_cmp, pos_cmp, dt_err);
  modport user (output cca, ndt, period, tri_mode,
                input  neg_cmp, pos_cmp, dt_err);
endinterface

// *** hw/pwmdt_params.svh ***
/*
  Register offsets, field positions, reset values and timing counts
  for the PWM channel with automatic dead time.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef PWMDT_PARAMS_SVH
`define PWMDT_PARAMS_SVH

// Widths
`define PWMDT_AW            4
`define PWMDT_DW            32
`define PWMDT_CW            16

// Register offsets on the plain register port
`define PWMDT_OFF_CTRL      4'h0
`define PWMDT_OFF_PERIOD    4'h1
`define PWMDT_OFF_CCA       4'h2
`define PWMDT_OFF_CCB       4'h3
`define PWMDT_OFF_NDT       4'h4
`define PWMDT_OFF_UPSR      4'h5
`define PWMDT_OFF_DNSR      4'h6
`define PWMDT_OFF_CNT       4'h7
`define PWMDT_OFF_STAT      4'h8
`define PWMDT_OFF_MASK      4'h9

// Control field positions
`define PWMDT_CTRL_RUN      0
`define PWMDT_CTRL_AUTODT   1
`define PWMDT_CTRL_CAPT     2
`define PWMDT_CTRL_MD_LO    4
`define PWMDT_CTRL_MD_HI    6
`define PWMDT_CTRL_USED     7'h77

// Mode field encodings
`define PWMDT_MD_TRI_BIT    2
`define PWMDT_MD_ONESHOT    2'h1

// Status bit positions
`define PWMDT_ST_DTERR      0
`define PWMDT_ST_CREST      1
`define PWMDT_ST_CAPT       2
`define PWMDT_ST_W          3

// Event source select width
`define PWMDT_SRC_W         2

// Reset values
`define PWMDT_RST_CTRL      7'h00
`define PWMDT_RST_PERIOD    16'hffff
`define PWMDT_RST_CC        16'h0000
`define PWMDT_RST_NDT       16'h0000

// Timing: recomputed value lands one count clock after an update
`define PWMDT_CLK_NS        10
`define PWMDT_LOAD_NS       10
`define PWMDT_LOAD_CYC      ((`PWMDT_LOAD_NS + `PWMDT_CLK_NS - 1) / `PWMDT_CLK_NS)

`endif

// *** hw/pwmdt_pkg.sv ***
/*
  Types shared by the PWM channel and its dead-time calculator.
  Assumes the params header is compiled alongside.
*/
package pwmdt_pkg;

  // Counter walk state
  typedef enum logic [1:0]
  {
    PWMDT_IDLE,
    PWMDT_UP,
    PWMDT_DOWN
  } pwmdt_state_t;

  typedef logic [15:0] pwmdt_cnt_t;

endpackage

// *** verification/pwmdt_channel_checker.sv ***
/*
  Port checker for the PWM channel with automatic dead time.
  Assumes a bind to pwmdt_channel; register shadows follow writes only.
*/
`timescale 1ns/1ps

module pwmdt_chk
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        up_event_pin,
  input wire logic        down_event_pin,
  input wire logic        capture_pin,
  input wire logic        pos_out,
  input wire logic        neg_out,
  input wire logic        irq
);
  logic [6:0]  ctrl_r;
  logic [15:0] a_r;
  logic [15:0] dt_r;
  logic [15:0] per_r;
  logic [2:0]  mask_r;
  logic        a_ok_r;
  logic [1:0]  q_r;
  logic [16:0] sum;
  logic [15:0] b_exp;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Shadows of the registers that steer the checks
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= 7'h00;
      a_r    <= 16'h0000;
      dt_r   <= 16'h0000;
      per_r  <= 16'hffff;
      mask_r <= 3'h0;
      a_ok_r <= 1'b1;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        4'h0: ctrl_r <= reg_wdata[6:0] & 7'h77;
        4'h1: per_r <= reg_wdata[15:0];
        4'h2: a_r <= reg_wdata[15:0];
        4'h4: dt_r <= reg_wdata[15:0];
        4'h9: mask_r <= reg_wdata[2:0];
        default: ;
      endcase
      if (reg_addr == 4'h2)
        a_ok_r <= !ctrl_r[2];
      else if (ctrl_r[2])
        a_ok_r <= 1'b0; // Capture may overwrite compare A
    end
    else if (ctrl_r[2])
      a_ok_r <= 1'b0;
  end

  // Cycles since the last write to a dead-time source, saturating
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_r <= 2'h0;
    else if (reg_wr && (reg_addr inside {4'h0, 4'h1, 4'h2, 4'h4}))
      q_r <= 2'h0;
    else if (q_r != 2'h3)
      q_r <= q_r + 2'h1;
  end

  // Expected compare B: A plus dead time, clipped at the period
  assign sum   = {1'b0, a_r} + {1'b0, dt_r};
  assign b_exp = (sum > {1'b0, per_r}) ? per_r : sum[15:0];

  rd_idle_a:
  assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  unmapped_zero_a:
  assert property (reg_rd && reg_addr >= 4'ha |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_back_a:
  assert property (reg_rd && reg_addr == 4'h0 |=>
                   reg_rdata == {25'h0, ctrl_r})
    else $error("control readback wrong");
  cca_keep_a:
  assert property (reg_rd && reg_addr == 4'h2 && a_ok_r |=>
                   reg_rdata == {16'h0, a_r})
    else $error("compare A changed by dead time");
  ccb_auto_a:
  assert property (reg_rd && reg_addr == 4'h3 && ctrl_r[1] && a_ok_r
                   && q_r == 2'h3 |=> reg_rdata == {16'h0, b_exp})
    else $error("compare B not the computed value");
  reset_quiet_a:
  assert property ($rose(rst_n) |-> !pos_out && !neg_out && !irq)
    else $error("outputs active right after reset");
  capt_outs_a:
  assert property (ctrl_r[2] && $past(ctrl_r[2], 2) |->
                   !pos_out && !neg_out)
    else $error("outputs driven in capture mode");
  irq_mask_a:
  assert property ($rose(irq) |-> $past(mask_r) != 3'h0)
    else $error("interrupt rose while fully masked");

  err_b_c: cover property (reg_rd && reg_addr == 4'h3 && sum > {1'b0, per_r});
  irq_c: cover property ($rose(irq));
  capt_c: cover property (ctrl_r[2] && $rose(capture_pin));
endmodule

bind pwmdt_channel pwmdt_chk i_chk
(
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .up_event_pin(up_event_pin), .down_event_pin(down_event_pin),
  .capture_pin(capture_pin), .pos_out(pos_out), .neg_out(neg_out),
  .irq(irq)
);

// *** verification/pwmdt_channel_tb.sv ***
/*
  Self-checking bench for the PWM channel with automatic dead time.
  Assumes the design files and the bound checker are compiled first.
*/
`timescale 1ns/1ps

module pwmdt_channel_tb;
  localparam logic [31:0] M = 32'hffff_ffff;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        up_p = 1'b0;
  logic        dn_p = 1'b0;
  logic        cap_p = 1'b0;
  logic [31:0] rdata;
  logic        pos;
  logic        neg;
  logic        irq;
  int          mismatches = 0;
  int          cmp_count = 0;

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  pwmdt_channel i_dut
  (
    .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .up_event_pin(up_p),
    .down_event_pin(dn_p), .capture_pin(cap_p), .pos_out(pos),
    .neg_out(neg), .irq(irq)
  );

  // Counts, verdict and stop
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read, data judged in the following cycle
  task automatic rdc(input logic [3:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask

  // Pulse the selected pins long enough to pass the synchronisers
  task automatic pulse(input logic [2:0] s);
    @(posedge clk);
    {cap_p, dn_p, up_p} <= s;
    repeat (6) @(posedge clk);
    {cap_p, dn_p, up_p} <= 3'h0;
    repeat (6) @(posedge clk);
  endtask

  task automatic wait_irq(input logic e);
    #1;
    for (int i = 0; i < 20 && irq !== e; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk({31'h0, irq}, {31'h0, e});
    if (irq !== e)
      end_of_test();
  endtask

  // Run a mode and count output high cycles over whole periods
  task automatic run_mode(input logic [2:0] md, input int n,
                          input int ep, input int en);
    int pc;
    int nc;
    pc = 0;
    nc = 0;
    wrr(4'h7, 32'h0);
    wrr(4'h0, {25'h0, md, 4'h0});
    wrr(4'h0, {25'h0, md, 4'h1});
    repeat (4) @(posedge clk);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      pc += int'(pos === 1'b1);
      nc += int'(neg === 1'b1);
    end
    chk(pc, ep);
    chk(nc, en);
    wrr(4'h0, {25'h0, md, 4'h0});
  endtask

  task automatic t_reset();
    rdc(4'h0, 32'h0, M);
    rdc(4'h1, 32'hffff, M);
    rdc(4'h3, 32'h0, M);
    rdc(4'hc, 32'h0, M);
  endtask

  // Dead-time error, compare B readback, reload and interrupt
  task automatic t_dt();
    wrr(4'h1, 32'h64);
    wrr(4'h2, 32'h5a);
    wrr(4'h4, 32'h14);
    wrr(4'h0, 32'h2);
    repeat (1) @(posedge clk);
    rdc(4'h3, 32'h64, M);
    rdc(4'h2, 32'h5a, M);
    rdc(4'h8, 32'h1, 32'h1);
    wrr(4'h9, 32'h1);
    wait_irq(1'b1);
    // No compare B write while auto dead time is on
    rdc(4'h3, 32'h64, M);
    wrr(4'h4, 32'h5);
    wrr(4'h2, 32'h1e);
    repeat (1) @(posedge clk);
    rdc(4'h3, 32'h23, M);
    wrr(4'h8, 32'h1);
    wait_irq(1'b0);
    wrr(4'h9, 32'h0);
    wrr(4'h0, 32'h0);
  endtask

  // Triangle crest reloads compare B and flags the error again
  task automatic t_tri();
    wrr(4'h1, 32'h64);
    wrr(4'h2, 32'h5a);
    wrr(4'h4, 32'h14);
    wrr(4'h7, 32'h0);
    wrr(4'h0, 32'h42);
    wrr(4'h0, 32'h43);
    repeat (3) @(posedge clk);
    wrr(4'h8, 32'h1);
    rdc(4'h8, 32'h0, 32'h1);
    repeat (250) @(posedge clk);
    rdc(4'h8, 32'h1, 32'h1);
    rdc(4'h3, 32'h64, M);
    wrr(4'h0, 32'h42);
    wrr(4'h0, 32'h0);
    wrr(4'h8, 32'h7);
  endtask

  // Saw, triangle and one-shot counting with period 3
  task automatic t_wave();
    wrr(4'h1, 32'h3);
    wrr(4'h2, 32'h1);
    wrr(4'h3, 32'h2);
    rdc(4'h3, 32'h2, M);
    run_mode(3'h0, 8, 2, 4);
    run_mode(3'h4, 12, 2, 6);
    run_mode(3'h7, 12, 2, 6);
    wrr(4'h7, 32'h0);
    wrr(4'h0, 32'h11);
    repeat (10) @(posedge clk);
    rdc(4'h7, 32'h3, M);
    wrr(4'h0, 32'h10);
  endtask

  // Event counting from both pins, mode held at zero
  task automatic t_evt();
    wrr(4'h7, 32'h0);
    wrr(4'h5, 32'h1);
    wrr(4'h6, 32'h2);
    wrr(4'h0, 32'h1);
    repeat (3) pulse(3'h1);
    rdc(4'h7, 32'h3, M);
    pulse(3'h2);
    rdc(4'h7, 32'h2, M);
    wrr(4'h0, 32'h0);
    wrr(4'h5, 32'h0);
    wrr(4'h6, 32'h0);
  endtask

  // Capture with low mode bits set, which must not matter
  task automatic t_capt();
    wrr(4'h8, 32'h7);
    wrr(4'h0, 32'h35);
    pulse(3'h4);
    rdc(4'h8, 32'h4, 32'h4);
    wrr(4'h0, 32'h0);
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_dt();
    t_tri();
    t_wave();
    t_evt();
    t_capt();
    end_of_test();
  end
endmodule
